// >>> hw/act_pkg.sv
// Shared constants, carrier types and states for the coincidence and time-stamp block.
package act_pkg;

    localparam int ADC_NUM = 8;
    localparam int ADC_W   = 16;
    localparam int TS_W    = 48;
    localparam int CNT_W   = 16;
    localparam int SEL_W   = 3;
    localparam int SER_W   = 32;

    localparam int CLK_NS        = 25;
    localparam int TS_RES_NS     = 50;
    localparam int TS_TICK_CYC   = (TS_RES_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] TICK_LAST = 8'(TS_TICK_CYC - 1);

    localparam int ID_TIME_MS     = 2000;
    localparam int BLINK_HALF_MS  = 250;
    localparam int ID_TIME_CYC    = ID_TIME_MS * (1000000 / CLK_NS);
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * (1000000 / CLK_NS);

    // Serial number default is an arbitrary value.
    localparam logic [SER_W-1:0] SERIAL_DEF = 32'h0000_5a5a;
    localparam logic [TS_W-1:0]  TS_RST     = 48'h0000_0000_0000;

    typedef logic [ADC_NUM-1:0][ADC_W-1:0] act_data_t;

    typedef struct packed {
        logic [ADC_NUM-1:0] start_en;
        logic [ADC_NUM-1:0] active_en;
        logic [CNT_W-1:0]   coinc_cyc;
        logic [CNT_W-1:0]   timeout_cyc;
        logic [SEL_W-1:0]   cap_sel;
        logic               aux1_dir_out;
        logic               aux1_out_val;
        logic               aux1_active_low;
        logic               ts_reset_aux;
        logic               ts_insert_en;
    } act_cfg_t;

    typedef struct packed {
        logic [ADC_NUM-1:0] mask;
        act_data_t          data;
        logic [TS_W-1:0]    ts;
    } act_evt_t;

    typedef enum logic [1:0] {ST_IDLE, ST_WINDOW, ST_WAIT, ST_EMIT} act_state_t;

endpackage

// >>> hw/act_coinc_ts.sv
// Coincidence gathering of converter results with 48-bit time stamping and identify.
`timescale 1ns/1ps
module act_coinc_ts #(
    parameter int unsigned               ID_CYC    = act_pkg::ID_TIME_CYC,
    parameter int unsigned               BLINK_CYC = act_pkg::BLINK_HALF_CYC,
    parameter logic [act_pkg::SER_W-1:0] SERIAL    = act_pkg::SERIAL_DEF
) (
    input  wire logic                          ref_clk,
    input  wire logic                          arst_n,
    input  act_pkg::act_cfg_t                  cfg,
    input  wire logic [act_pkg::ADC_NUM-1:0]   conv_busy,
    input  wire logic [act_pkg::ADC_NUM-1:0]   conv_done,
    input  act_pkg::act_data_t                 conv_data,
    input  wire logic                          aux1_in,
    input  wire logic                          id_req,
    output logic [act_pkg::ADC_NUM-1:0]        conv_ack,
    output logic                               evt_valid,
    output act_pkg::act_evt_t                  evt,
    output logic                               aux1_out,
    output logic                               aux1_oe,
    output logic                               id_valid,
    output logic [act_pkg::SER_W-1:0]          id_serial,
    output logic                               id_led
);
    import act_pkg::*;

    // Pin synchronisers; the data bus is synchronised too, through the same two stages as done.
    logic [ADC_NUM-1:0] busy_m, busy_s, busy_d, done_m, done_s;
    act_data_t          data_m, data_s;
    logic               aux_m, aux_s;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_m <= '0;
            busy_s <= '0;
            busy_d <= '0;
            done_m <= '0;
            done_s <= '0;
            data_m <= '0;
            data_s <= '0;
            aux_m  <= 1'b0;
            aux_s  <= 1'b0;
        end else begin
            busy_m <= conv_busy;
            busy_s <= busy_m;
            busy_d <= busy_s;
            done_m <= conv_done;
            done_s <= done_m;
            data_m <= conv_data;
            data_s <= data_m;
            aux_m  <= aux1_in;
            aux_s  <= aux_m;
        end
    end

    logic [ADC_NUM-1:0] busy_rise;
    assign busy_rise = busy_s & ~busy_d;

    // Event gathering.
    act_state_t         st_reg, st_next;
    logic [CNT_W-1:0]   cnt_reg, cnt_next;
    logic [ADC_NUM-1:0] hit_reg, hit_next, got_reg, got_next, ack_reg, ack_next;
    act_data_t          data_reg, data_next;
    logic               evt_valid_reg, evt_valid_next;
    act_evt_t           evt_reg, evt_next;
    logic [TS_W-1:0]    ts_reg, ts_next, ts_cap_reg, ts_cap_next;
    logic [ADC_NUM-1:0] open_req, take;

    always_comb begin
        st_next        = st_reg;
        cnt_next       = cnt_reg;
        hit_next       = hit_reg;
        got_next       = got_reg;
        data_next      = data_reg;
        ack_next       = '0;
        evt_valid_next = 1'b0;
        evt_next       = evt_reg;
        open_req       = busy_rise & cfg.start_en & cfg.active_en;
        take           = hit_reg & done_s & ~got_reg;
        unique case (st_reg)
            ST_IDLE: begin
                if (|open_req) begin
                    st_next   = ST_WINDOW;
                    cnt_next  = cfg.coinc_cyc;
                    hit_next  = busy_rise & cfg.active_en;
                    got_next  = '0;
                    data_next = '0;
                end
            end
            ST_WINDOW: begin
                // Non-start converters may only join, here or in the opening cycle, never open.
                hit_next = hit_reg | (busy_rise & cfg.active_en);
                if (cnt_reg == '0) begin
                    st_next  = ST_WAIT;
                    cnt_next = cfg.timeout_cyc;
                end else begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end
            end
            ST_WAIT: begin
                got_next = got_reg | take;
                ack_next = take;
                for (int i = 0; i < ADC_NUM; i++) begin
                    if (take[i]) begin
                        data_next[i] = data_s[i];
                    end
                end
                if ((got_reg | take) == hit_reg) begin
                    st_next = ST_EMIT;
                end else if (cnt_reg == '0) begin
                    st_next = ST_EMIT;
                end else begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end
            end
            ST_EMIT: begin
                // Missing converters keep the zero loaded at window open.
                evt_valid_next = 1'b1;
                evt_next.mask  = got_reg;
                evt_next.data  = data_reg;
                evt_next.ts    = cfg.ts_insert_en ? ts_cap_reg : TS_RST;
                st_next        = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg        <= ST_IDLE;
            cnt_reg       <= '0;
            hit_reg       <= '0;
            got_reg       <= '0;
            data_reg      <= '0;
            ack_reg       <= '0;
            evt_valid_reg <= 1'b0;
            evt_reg       <= '0;
        end else begin
            st_reg        <= st_next;
            cnt_reg       <= cnt_next;
            hit_reg       <= hit_next;
            got_reg       <= got_next;
            data_reg      <= data_next;
            ack_reg       <= ack_next;
            evt_valid_reg <= evt_valid_next;
            evt_reg       <= evt_next;
        end
    end

    // Time stamp counter, one count per resolution step rather than per clock.
    logic [7:0] tick_reg, tick_next;
    logic       aux_act, ts_rld, cap_rise;

    // With ts_reset_aux set, the counter is held in reload while the synchronised input equals aux1_active_low and runs at the other level.
    assign aux_act  = ~(aux_s ^ cfg.aux1_active_low);
    assign ts_rld   = cfg.ts_reset_aux & aux_act;
    assign cap_rise = busy_rise[cfg.cap_sel];

    always_comb begin
        tick_next   = (tick_reg == TICK_LAST) ? 8'h00 : tick_reg + 8'h01;
        ts_next     = (tick_reg == TICK_LAST) ? ts_reg + 48'h1 : ts_reg;
        ts_cap_next = cap_rise ? ts_reg : ts_cap_reg;
        if (ts_rld) begin
            tick_next = 8'h00;
            ts_next   = TS_RST;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_reg   <= 8'h00;
            ts_reg     <= TS_RST;
            ts_cap_reg <= TS_RST;
        end else begin
            tick_reg   <= tick_next;
            ts_reg     <= ts_next;
            ts_cap_reg <= ts_cap_next;
        end
    end

    // Auxiliary pin driver and identify indication.
    logic             aux_oe_reg, aux_out_reg, id_valid_reg, led_reg;
    logic             led_next;
    logic [SER_W-1:0] ser_reg, ser_next;
    logic [31:0]      id_cnt_reg, id_cnt_next, blink_reg, blink_next;

    always_comb begin
        ser_next    = id_req ? SERIAL : ser_reg;
        id_cnt_next = id_cnt_reg;
        blink_next  = blink_reg;
        led_next    = led_reg;
        if (id_req) begin
            id_cnt_next = 32'(ID_CYC);
            blink_next  = 32'h0;
            led_next    = 1'b1;
        end else if (id_cnt_reg != 32'h0) begin
            id_cnt_next = id_cnt_reg - 32'h1;
            if (blink_reg >= 32'(BLINK_CYC) - 32'h1) begin
                blink_next = 32'h0;
                led_next   = ~led_reg;
            end else begin
                blink_next = blink_reg + 32'h1;
            end
        end else begin
            led_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            aux_oe_reg   <= 1'b0;
            aux_out_reg  <= 1'b0;
            id_valid_reg <= 1'b0;
            ser_reg      <= '0;
            id_cnt_reg   <= 32'h0;
            blink_reg    <= 32'h0;
            led_reg      <= 1'b0;
        end else begin
            aux_oe_reg   <= cfg.aux1_dir_out;
            aux_out_reg  <= cfg.aux1_out_val;
            id_valid_reg <= id_req;
            ser_reg      <= ser_next;
            id_cnt_reg   <= id_cnt_next;
            blink_reg    <= blink_next;
            led_reg      <= led_next;
        end
    end

    assign conv_ack  = ack_reg;
    assign evt_valid = evt_valid_reg;
    assign evt       = evt_reg;
    assign aux1_out  = aux_out_reg;
    assign aux1_oe   = aux_oe_reg;
    assign id_valid  = id_valid_reg;
    assign id_serial = ser_reg;
    assign id_led    = led_reg;

    // Checks; the helper flags any absent converter reported with nonzero data.
    logic miss_nz;
    always_comb begin
        miss_nz = 1'b0;
        for (int i = 0; i < ADC_NUM; i++) begin
            if (!evt_reg.mask[i] && evt_reg.data[i] != '0) begin
                miss_nz = 1'b1;
            end
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    window_open_a: assert property (
        (st_reg == ST_IDLE && st_next == ST_WINDOW) |-> |(busy_rise & cfg.start_en & cfg.active_en))
        else $error("Window opened without a start-enabled converter.");
    window_hold_a: assert property (
        (st_reg == ST_WINDOW && cnt_reg != '0) |=> st_reg == ST_WINDOW && cnt_reg == $past(cnt_reg) - 1'b1)
        else $error("Coincidence window ended early.");
    window_close_a: assert property (
        (st_reg == ST_WINDOW && cnt_reg == '0) |=> st_reg == ST_WAIT && cnt_reg == $past(cfg.timeout_cyc))
        else $error("Wait phase not started with the timeout.");
    done_timeout_a: assert property (
        (st_reg == ST_WAIT && cnt_reg == '0) |=> st_reg == ST_EMIT ##1 st_reg == ST_IDLE && evt_valid_reg)
        else $error("Timeout did not close the event.");
    zero_fill_a: assert property (
        evt_valid_reg |-> !miss_nz)
        else $error("Absent converter reported nonzero.");
    ts_reload_a: assert property (
        (cfg.ts_reset_aux && (aux_s == cfg.aux1_active_low)) |=> ts_reg == TS_RST)
        else $error("Time stamp not reloaded by auxiliary input.");
    ts_tick_a: assert property (
        (!ts_rld && tick_reg == 8'h00) |=> ts_reg == $past(ts_reg))
        else $error("Time stamp moved inside a resolution step.");
    ts_step_a: assert property (
        (!ts_rld && tick_reg == 8'h00) ##1 !ts_rld |=> ts_reg == $past(ts_reg, 2) + 48'h1)
        else $error("Time stamp step is not one per resolution step.");
    wait_hold_a: assert property (
        (st_reg == ST_WAIT) |=> hit_reg == $past(hit_reg))
        else $error("Converter joined after the window closed.");
    ack_joined_a: assert property (
        |conv_ack |-> (conv_ack & ~hit_reg) == '0)
        else $error("Data taken from a converter that did not join.");
    mask_joined_a: assert property (
        evt_valid_reg |-> (evt_reg.mask & ~hit_reg) == '0)
        else $error("Event marks a converter that did not join.");
    evt_pulse_a: assert property (
        evt_valid_reg |=> !evt_valid_reg)
        else $error("Event valid stood longer than one cycle.");
    aux_drive_a: assert property (
        cfg.aux1_dir_out |=> aux1_oe && aux1_out == $past(cfg.aux1_out_val))
        else $error("Auxiliary driver not following its setting.");
    led_idle_a: assert property (
        (id_cnt_reg == 32'h0 && !id_req) |=> !id_led)
        else $error("Indicator lit outside identify.");
    ts_capture_a: assert property (
        busy_rise[cfg.cap_sel] |=> ts_cap_reg == $past(ts_reg))
        else $error("Time stamp not captured on busy edge.");
    ts_insert_a: assert property (
        (st_reg == ST_EMIT && cfg.ts_insert_en) |=> evt_valid_reg && evt_reg.ts == $past(ts_cap_reg))
        else $error("Captured time stamp missing from event.");
    aux_input_a: assert property (
        !cfg.aux1_dir_out |=> !aux1_oe)
        else $error("Auxiliary driver enabled while used as input.");
    identify_a: assert property (
        id_req |=> id_valid && id_serial == SERIAL && id_led)
        else $error("Identify did not report serial and light indicators.");

endmodule

// >>> verification/act_conv_model.sv
// Behavioural model of the external converters that feed the block.
`timescale 1ns/1ps
module act_conv_model (
    input  wire logic                        ref_clk,
    input  wire logic [act_pkg::ADC_NUM-1:0] fire,
    input  wire logic [7:0]                  conv_len,
    input  act_pkg::act_data_t               value,
    input  wire logic [act_pkg::ADC_NUM-1:0] conv_ack,
    output logic [act_pkg::ADC_NUM-1:0]      conv_busy,
    output logic [act_pkg::ADC_NUM-1:0]      conv_done,
    output act_pkg::act_data_t               conv_data
);
    import act_pkg::*;
    logic [7:0] age [ADC_NUM];
    initial begin
        conv_busy = '0;
        conv_done = '0;
        conv_data = '0;
    end
    // A converter that is never acknowledged gives up after 40 cycles so that it can fire again.
    always @(posedge ref_clk) begin
        for (int i = 0; i < ADC_NUM; i++) begin
            if (!conv_busy[i]) begin
                conv_busy[i] <= fire[i];
                age[i]       <= 8'h00;
                conv_data[i] <= ~conv_data[i];
            end else begin
                age[i] <= age[i] + 8'h01;
                if (!conv_done[i] && age[i] == conv_len) begin
                    conv_done[i] <= 1'b1;
                    conv_data[i] <= value[i];
                end else if (conv_done[i] && (conv_ack[i] || age[i] > conv_len + 8'h28)) begin
                    conv_done[i] <= 1'b0;
                    conv_busy[i] <= 1'b0;
                    conv_data[i] <= ~conv_data[i];
                end
            end
        end
    end
endmodule

// >>> verification/act_coinc_ts_bench.sv
// Self-checking bench for the coincidence and time-stamp block.
`timescale 1ns/1ps
module act_coinc_ts_bench;
    import act_pkg::*;
    typedef struct packed {
        act_evt_t   e;
        logic [1:0] kind;
    } act_note_t;
    logic               ref_clk     = 1'b0;
    logic               arst_n      = 1'b0;
    logic [ADC_NUM-1:0] fire        = '0;
    logic [7:0]         conv_len    = 8'h04;
    logic               aux1_in     = 1'b0;
    logic               id_req      = 1'b0;
    logic [31:0]        lfsr_state  = 32'h5776;
    logic [TS_W-1:0]    prev_ts     = '0;
    int                 mismatches  = 0;
    int                 checks_done = 0;
    int                 n;
    logic               reload;
    act_cfg_t           cfg;
    act_data_t          value;
    act_data_t          conv_data;
    logic [ADC_NUM-1:0] conv_busy, conv_done, conv_ack;
    logic               evt_valid, aux1_out, aux1_oe, id_valid, id_led;
    logic [SER_W-1:0]   id_serial;
    act_evt_t           evt;
    act_note_t          notes[$];
    act_note_t          note;

    always #12.5 ref_clk = ~ref_clk;

    act_conv_model i_act_conv_model (.ref_clk(ref_clk), .fire(fire), .conv_len(conv_len),
        .value(value), .conv_ack(conv_ack), .conv_busy(conv_busy), .conv_done(conv_done),
        .conv_data(conv_data));

    act_coinc_ts #(.ID_CYC(40), .BLINK_CYC(4)) i_act_coinc_ts (.ref_clk(ref_clk),
        .arst_n(arst_n), .cfg(cfg), .conv_busy(conv_busy), .conv_done(conv_done),
        .conv_data(conv_data), .aux1_in(aux1_in), .id_req(id_req), .conv_ack(conv_ack),
        .evt_valid(evt_valid), .evt(evt), .aux1_out(aux1_out), .aux1_oe(aux1_oe),
        .id_valid(id_valid), .id_serial(id_serial), .id_led(id_led));

    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] want);
        checks_done++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask

    task automatic wrap_up;
        if (mismatches == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], ^(s & 32'h8020_0003)};
    endfunction

    task automatic new_values;
        for (int i = 0; i < ADC_NUM; i++) begin
            lfsr_state = lfsr_next(lfsr_state);
            value[i]   = lfsr_state[15:0];
        end
    endtask

    task automatic expect_evt(input logic [7:0] m, input logic [1:0] kind, input logic [47:0] t);
        act_note_t nt;
        nt.e.mask = m;
        nt.e.ts   = t;
        nt.kind   = kind;
        for (int i = 0; i < ADC_NUM; i++) begin
            nt.e.data[i] = m[i] ? value[i] : 16'h0000;
        end
        notes.push_back(nt);
    endtask

    task automatic pulse(input logic [7:0] m, input int gap);
        fire = m;
        @(negedge ref_clk);
        fire = '0;
        repeat (gap) @(negedge ref_clk);
    endtask

    task automatic drain;
        for (int k = 0; k < 400 && notes.size() != 0; k++) @(negedge ref_clk);
        check("pending events", 128'(notes.size()), 128'h0);
        repeat (120) @(negedge ref_clk);
    endtask

    // Outputs are taken at the falling edge, where every registered value has settled.
    always @(negedge ref_clk) begin
        if (evt_valid === 1'b1) begin
            if (notes.size() == 0) begin
                check("spare event", 128'h1, 128'h0);
            end else begin
                note = notes.pop_front();
                check("mask", 128'(evt.mask), 128'(note.e.mask));
                check("data", 128'(evt.data), 128'(note.e.data));
                if (note.kind == 2'd0) check("ts", 128'(evt.ts), 128'(note.e.ts));
                if (note.kind == 2'd1) check("ts step", 128'(evt.ts - prev_ts), 128'(note.e.ts));
            end
            prev_ts = evt.ts;
        end
    end

    initial begin
        cfg             = '0;
        value           = '0;
        cfg.coinc_cyc   = 16'h000a;
        cfg.timeout_cyc = 16'h0014;
        cfg.start_en    = 8'h05;
        cfg.active_en   = 8'h03;
        repeat (4) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        // Alone, partner on the last window cycle, partner one cycle too late.
        for (int g = 0; g < 3; g++) begin
            new_values();
            expect_evt(g == 1 ? 8'h03 : 8'h01, 2'd0, '0);
            pulse(8'h01, g == 0 ? 0 : 9 + g);
            if (g != 0) pulse(8'h02, 0);
            drain();
        end
        // Joiner without start permission and an inactive starter must open nothing.
        pulse(8'h06, 0);
        drain();
        conv_len = 8'h3c;
        new_values();
        expect_evt(8'h00, 2'd0, '0);
        pulse(8'h01, 0);
        drain();
        conv_len         = 8'h04;
        cfg.ts_insert_en = 1'b1;
        for (int k = 0; k < 8; k++) begin
            {cfg.ts_reset_aux, cfg.aux1_active_low, aux1_in} = 3'(k);
            reload = k[2] & (k[1] == k[0]);
            repeat (8) @(negedge ref_clk);
            new_values();
            expect_evt(8'h01, reload ? 2'd0 : 2'd2, '0);
            pulse(8'h01, 199);
            new_values();
            expect_evt(8'h01, reload ? 2'd0 : 2'd1, reload ? '0 : 48'd100);
            pulse(8'h01, 0);
            drain();
        end
        for (int k = 0; k < 4; k++) begin
            {cfg.aux1_dir_out, cfg.aux1_out_val} = 2'(k);
            repeat (2) @(negedge ref_clk);
            check("aux1_oe", 128'(aux1_oe), 128'(k[1]));
            if (k[1]) check("aux1_out", 128'(aux1_out), 128'(k[0]));
        end
        id_req = 1'b1;
        @(negedge ref_clk);
        id_req = 1'b0;
        for (int k = 0; k < 3 && id_valid !== 1'b1; k++) @(negedge ref_clk);
        check("id_valid", 128'(id_valid), 128'h1);
        check("id_serial", 128'(id_serial), 128'(SERIAL_DEF));
        n = 0;
        repeat (36) begin
            @(negedge ref_clk);
            n += int'(id_led === 1'b1);
        end
        check("id_led blink", 128'(n > 8 && n < 28), 128'h1);
        repeat (12) @(negedge ref_clk);
        check("id_led idle", 128'(id_led), 128'h0);
        wrap_up();
    end

    // The sequence needs about 3500 cycles; 20000 leaves ample margin for a hang.
    initial begin
        #500000;
        mismatches++;
        wrap_up();
    end
endmodule
